// ===== logic/display_keyboard_scanner_defs.vh
// constants for the display and keyboard scanner: timings, key indices, sizes
// assumes a 250 MHz mclk; times are kept in their own unit, cycle counts derived
`ifndef DISPLAY_KEYBOARD_SCANNER_DEFS_VH
`define DISPLAY_KEYBOARD_SCANNER_DEFS_VH

`define MCLK_MHZ 250
`define REF_CLK_KHZ 1000

`define NUM_DIGITS 8
`define NUM_RETURNS 7
`define NUM_KEY_COLS 3
`define NUM_KEYS 21
`define SCAN_DWELL_TICKS 500

`define KEY_SRQ_INDEX 0
`define KEY_UNUSED_INDEX 13
`define SEG_ALL_ON 7'h7f

`define KEY_PULSE_US 100
`define KEY_PULSE_CYC (`KEY_PULSE_US * `MCLK_MHZ)

`define POWERUP_WINDOW_MS 1000
`define POWERUP_WINDOW_CYC (`POWERUP_WINDOW_MS * `MCLK_MHZ * 1000)

`define FAST_PULSE_NS 200
`define FAST_PULSE_CYC (`FAST_PULSE_NS * `MCLK_MHZ / 1000)
`define FAST_SPACE_A_NS 25000
`define FAST_SPACE_A_CYC (`FAST_SPACE_A_NS * `MCLK_MHZ / 1000)
`define FAST_SPACE_B_NS 7100
`define FAST_SPACE_B_CYC (`FAST_SPACE_B_NS * `MCLK_MHZ / 1000)
`define FAST_B_START_NS 150000
`define FAST_B_START_CYC (`FAST_B_START_NS * `MCLK_MHZ / 1000)
`define FAST_COUNT_A 3
`define FAST_COUNT_B 15
`define FAST_PERIOD_MS 10
`define FAST_PERIOD_CYC (`FAST_PERIOD_MS * `MCLK_MHZ * 1000)

`define SLOW_PULSE_NS 400
`define SLOW_PULSE_CYC (`SLOW_PULSE_NS * `MCLK_MHZ / 1000)
`define SLOW_SPACE_NS 10000
`define SLOW_SPACE_CYC (`SLOW_SPACE_NS * `MCLK_MHZ / 1000)
`define SLOW_COUNT 375
`define SLOW_PERIOD_MS 8
`define SLOW_PERIOD_CYC (`SLOW_PERIOD_MS * `MCLK_MHZ * 1000)

`endif

// ===== logic/select_burst_gen.v
// select pulse burst generator: up to two groups of active-low pulses per period
// assumes enable comes from logic on mclk; counts are cycles of mclk
`timescale 1ns/1ns
`default_nettype none

module select_burst_gen #(
  parameter integer PULSE_CYC = 50,
  parameter integer SPACE_A_CYC = 4000,
  parameter integer SPACE_B_CYC = 1650,
  parameter integer COUNT_A = 3,
  parameter integer COUNT_B = 15,
  parameter integer B_START_CYC = 37500,
  parameter integer PERIOD_CYC = 2500000
) (
  input wire mclk,
  input wire rst_n,
  input wire enable,
  output reg select_n
);

  localparam [23:0] PERIOD_LAST = PERIOD_CYC[23:0] - 24'h000001;
  localparam [23:0] B_START = B_START_CYC[23:0];
  localparam [15:0] PULSE_LEN = PULSE_CYC[15:0];
  localparam [15:0] SPACE_A = SPACE_A_CYC[15:0];
  localparam [15:0] SPACE_B = SPACE_B_CYC[15:0];
  localparam [9:0] CNT_A = COUNT_A[9:0];
  localparam [9:0] CNT_B = COUNT_B[9:0];

  reg [23:0] period_reg;
  reg [15:0] phase_reg;
  reg [15:0] space_reg;
  reg [9:0] left_reg;

  always @(posedge mclk) begin
    if (!rst_n || !enable) begin
      period_reg <= 24'h000000;
      phase_reg <= 16'h0000;
      space_reg <= 16'h0000;
      left_reg <= 10'h000;
      select_n <= 1'b1;
    end else begin
      period_reg <= (period_reg == PERIOD_LAST) ? 24'h000000 : period_reg + 24'h000001;
      if (period_reg == 24'h000000) begin
        left_reg <= CNT_A;
        phase_reg <= 16'h0000;
        space_reg <= SPACE_A;
      end else if (CNT_B != 10'h000 && period_reg == B_START) begin
        left_reg <= CNT_B;
        phase_reg <= 16'h0000;
        space_reg <= SPACE_B;
      end else if (left_reg != 10'h000) begin
        if (phase_reg == space_reg - 16'h0001) begin
          phase_reg <= 16'h0000;
          left_reg <= left_reg - 10'h001;
        end else begin
          phase_reg <= phase_reg + 16'h0001;
        end
      end
      // low only in the head of each spacing slot of a live group
      select_n <= !(left_reg != 10'h000 && phase_reg < PULSE_LEN);
    end
  end

endmodule

`default_nettype wire

// ===== logic/display_keyboard_scanner.v
// display and keyboard scanner: digit strobes, segment data, key matrix sensing,
// key activity pulse, display test state and the two combined select outputs
// assumes ref_clk_1mhz and the return lines are asynchronous pins; digit_codes,
// fast_rate come from logic on mclk
`timescale 1ns/1ns
`default_nettype none
`include "display_keyboard_scanner_defs.vh"

// Overview of operation
// R1: scan steps on the 1 MHz reference clock brought in from outside.
// R2: eight separate digit strobes, zero to seven, one per digit output.
// R3: three-bit scan select decoded 3-to-8 into the digit strobes.
// R4: four-bit digit code decoded into seven segment lines for strobed digit.
// R5: held key puts its inverted column strobe on its return line.
// R6: column zero rows 0-6: srq, local, rate, offset, 20M, trigger, ext trigger.
// R7: column one rows 0-5 range keys; row six unused.
// R8: column two rows 0-6: function keys and autorange.
// R9: each key press in normal mode gives 50-300 us pulse plus inverse.
// R10: fast rate select: 0.2 us low pulses, bursts of 3 and 15, every 10 ms.
// R11: second select: 0.4 us low pulses, bursts of hundreds, about 8 ms apart.
// R12: in display test any key press releases it; then normal operation.
// R13: srq within one second of power-up enters all-segments display test.
// R14: one strobe at most active; scan cycles through all eight positions.
module display_keyboard_scanner #(
  parameter integer POWERUP_WINDOW_CYC = `POWERUP_WINDOW_CYC,
  parameter integer FAST_PERIOD_CYC = `FAST_PERIOD_CYC,
  parameter integer SLOW_PERIOD_CYC = `SLOW_PERIOD_CYC,
  parameter integer SCAN_DWELL_TICKS = `SCAN_DWELL_TICKS,
  parameter integer KEY_PULSE_CYC = `KEY_PULSE_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire ref_clk_1mhz,
  input wire [31:0] digit_codes,
  input wire fast_rate,
  input wire key_return_line0,
  input wire key_return_line1,
  input wire key_return_line2,
  input wire key_return_line3,
  input wire key_return_line4,
  input wire key_return_line5,
  input wire key_return_line6,
  output reg scan_select_bit0,
  output reg scan_select_bit1,
  output reg scan_select_bit2,
  output reg [7:0] digit_strobe,
  output reg [6:0] segment_drive,
  output reg key_activity,
  output reg key_activity_n,
  output reg [4:0] key_code,
  output reg display_test,
  output reg normal_operation,
  output wire fast_select_n,
  output wire slow_select_n
);

  localparam [9:0] DWELL_LAST = SCAN_DWELL_TICKS[9:0] - 10'h001;
  localparam [31:0] WINDOW_LAST = POWERUP_WINDOW_CYC[31:0] - 32'h00000001;
  localparam [15:0] KEY_PULSE_LEN = KEY_PULSE_CYC[15:0];

  localparam [1:0] ST_WINDOW = 2'h0;
  localparam [1:0] ST_TEST = 2'h1;
  localparam [1:0] ST_NORMAL = 2'h2;

  // reference clock: two flops, then an edge detector behind them
  reg ref_meta_reg;
  reg ref_sync_reg;
  reg ref_prev_reg;
  wire ref_tick = ref_sync_reg && !ref_prev_reg;

  always @(posedge mclk) begin
    if (!rst_n) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_meta_reg <= ref_clk_1mhz;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
    end
  end

  // return lines synchronised; active low while a key is held
  wire [6:0] return_raw = {key_return_line6, key_return_line5, key_return_line4, key_return_line3,
                           key_return_line2, key_return_line1, key_return_line0};
  reg [6:0] return_meta_reg;
  reg [6:0] return_sync_reg;

  always @(posedge mclk) begin
    if (!rst_n) begin
      return_meta_reg <= 7'h7f;
      return_sync_reg <= 7'h7f;
    end else begin
      return_meta_reg <= return_raw;
      return_sync_reg <= return_meta_reg;
    end
  end

  // scan position and dwell counter
  reg [2:0] sel_reg;
  reg [9:0] dwell_reg;
  wire dwell_end = ref_tick && (dwell_reg == DWELL_LAST);
  wire [2:0] sel_next = dwell_end ? sel_reg + 3'h1 : sel_reg;

  always @(posedge mclk) begin
    if (!rst_n) begin
      sel_reg <= 3'h0;
      dwell_reg <= 10'h000;
    end else begin
      if (ref_tick) begin
        dwell_reg <= dwell_end ? 10'h000 : dwell_reg + 10'h001; // R1
      end
      sel_reg <= sel_next; // R14
    end
  end

  // select bits and strobes registered from the same next value so they agree
  always @(posedge mclk) begin
    if (!rst_n) begin
      scan_select_bit0 <= 1'b0;
      scan_select_bit1 <= 1'b0;
      scan_select_bit2 <= 1'b0;
      digit_strobe <= 8'h00;
    end else begin
      scan_select_bit0 <= sel_next[0]; // R3
      scan_select_bit1 <= sel_next[1]; // R3
      scan_select_bit2 <= sel_next[2]; // R3
      digit_strobe <= 8'h01 << sel_next; // R2 R3 R14
    end
  end

  // key matrix: sample rows at the end of each dwell, when returns have settled.
  // bit index = column * 7 + row; columns 3..7 carry no keys.
  reg [20:0] key_held_reg;
  reg [20:0] key_held_prev_reg;
  wire [20:0] key_press = key_held_reg & ~key_held_prev_reg;

  genvar k;
  generate
    for (k = 0; k < `NUM_KEYS; k = k + 1) begin : key_cell
      localparam integer COL = k / `NUM_RETURNS;
      localparam integer ROW = k % `NUM_RETURNS;
      always @(posedge mclk) begin
        if (!rst_n) begin
          key_held_reg[k] <= 1'b0;
        end else if (k == `KEY_UNUSED_INDEX) begin
          key_held_reg[k] <= 1'b0; // R7
        end else if (dwell_end && sel_reg == COL[2:0]) begin
          key_held_reg[k] <= !return_sync_reg[ROW]; // R5 R6 R7 R8
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (!rst_n) begin
      key_held_prev_reg <= 21'h000000;
    end else begin
      key_held_prev_reg <= key_held_reg;
    end
  end

  // lowest index wins if two keys appear in the same sample
  reg [4:0] press_code;
  reg press_any;
  integer i;
  always @* begin
    press_code = 5'h00;
    press_any = 1'b0;
    for (i = `NUM_KEYS - 1; i >= 0; i = i - 1) begin
      if (key_press[i]) begin
        press_code = i[4:0];
        press_any = 1'b1;
      end
    end
  end

  // power-up window, display test and normal operation
  reg [1:0] state_reg;
  reg [31:0] window_reg;

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_WINDOW;
      window_reg <= 32'h00000000;
      display_test <= 1'b0;
      normal_operation <= 1'b0;
    end else begin
      case (state_reg)
        ST_WINDOW: begin
          window_reg <= window_reg + 32'h00000001;
          if (key_press[`KEY_SRQ_INDEX]) begin
            state_reg <= ST_TEST; // R13
            display_test <= 1'b1;
          end else if (window_reg == WINDOW_LAST) begin
            state_reg <= ST_NORMAL;
            normal_operation <= 1'b1;
          end
        end
        ST_TEST: begin
          if (press_any) begin
            state_reg <= ST_NORMAL; // R12
            display_test <= 1'b0;
            normal_operation <= 1'b1;
          end
        end
        ST_NORMAL: begin
          normal_operation <= 1'b1;
        end
        default: begin
          state_reg <= ST_WINDOW;
          display_test <= 1'b0;
          normal_operation <= 1'b0;
        end
      endcase
    end
  end

  // segment data for the digit being strobed next; test lights everything
  wire [3:0] digit_now = digit_codes[sel_next * 4 +: 4];
  reg [6:0] seg_pattern;
  always @* begin
    case (digit_now)
      4'h0: seg_pattern = 7'h3f;
      4'h1: seg_pattern = 7'h06;
      4'h2: seg_pattern = 7'h5b;
      4'h3: seg_pattern = 7'h4f;
      4'h4: seg_pattern = 7'h66;
      4'h5: seg_pattern = 7'h6d;
      4'h6: seg_pattern = 7'h7d;
      4'h7: seg_pattern = 7'h07;
      4'h8: seg_pattern = 7'h7f;
      4'h9: seg_pattern = 7'h6f;
      4'ha: seg_pattern = 7'h77;
      4'hb: seg_pattern = 7'h7c;
      4'hc: seg_pattern = 7'h39;
      4'hd: seg_pattern = 7'h5e;
      4'he: seg_pattern = 7'h79;
      default: seg_pattern = 7'h71;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      segment_drive <= 7'h00;
    end else if (state_reg == ST_TEST) begin
      segment_drive <= `SEG_ALL_ON; // R13
    end else begin
      segment_drive <= seg_pattern; // R4
    end
  end

  // key activity pulse: retriggered by each new press, normal mode only
  reg [15:0] pulse_reg;
  always @(posedge mclk) begin
    if (!rst_n) begin
      pulse_reg <= 16'h0000;
      key_activity <= 1'b0;
      key_activity_n <= 1'b1;
      key_code <= 5'h00;
    end else begin
      if (press_any) begin
        key_code <= press_code; // R5
      end
      if (press_any && state_reg == ST_NORMAL) begin
        pulse_reg <= KEY_PULSE_LEN; // R9
        key_activity <= 1'b1;
        key_activity_n <= 1'b0;
      end else if (pulse_reg > 16'h0001) begin
        pulse_reg <= pulse_reg - 16'h0001;
      end else begin
        pulse_reg <= 16'h0000;
        key_activity <= 1'b0; // R9
        key_activity_n <= 1'b1;
      end
    end
  end

  // fast group runs only in fast reading rate and after start-up
  wire fast_enable = fast_rate && normal_operation;

  select_burst_gen #(
    .PULSE_CYC(`FAST_PULSE_CYC),
    .SPACE_A_CYC(`FAST_SPACE_A_CYC),
    .SPACE_B_CYC(`FAST_SPACE_B_CYC),
    .COUNT_A(`FAST_COUNT_A),
    .COUNT_B(`FAST_COUNT_B),
    .B_START_CYC(`FAST_B_START_CYC),
    .PERIOD_CYC(FAST_PERIOD_CYC)
  ) fast_gen (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(fast_enable), // R10
    .select_n(fast_select_n)
  );

  select_burst_gen #(
    .PULSE_CYC(`SLOW_PULSE_CYC),
    .SPACE_A_CYC(`SLOW_SPACE_CYC),
    .SPACE_B_CYC(`SLOW_SPACE_CYC),
    .COUNT_A(`SLOW_COUNT),
    .COUNT_B(0),
    .B_START_CYC(1),
    .PERIOD_CYC(SLOW_PERIOD_CYC)
  ) slow_gen (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(normal_operation), // R11
    .select_n(slow_select_n)
  );

endmodule

`default_nettype wire

// ===== dv/scanner_checker_assertions.sv
// checker for the display and keyboard scanner top ports
// assumes 250 MHz mclk, a two-tick dwell and the pulse widths of the header
`timescale 1ns/1ns
`default_nettype none
module scanner_checker (
  input wire mclk,
  input wire rst_n,
  input wire fast_rate,
  input wire scan_select_bit0,
  input wire scan_select_bit1,
  input wire scan_select_bit2,
  input wire [7:0] digit_strobe,
  input wire [6:0] segment_drive,
  input wire key_activity,
  input wire key_activity_n,
  input wire display_test,
  input wire normal_operation,
  input wire fast_select_n,
  input wire slow_select_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] prev_reg;
  always @(posedge mclk) prev_reg <= digit_strobe;

  a_strobe_single: assert property ($onehot0(digit_strobe))
    else $error("more than one digit strobe");
  a_select_decode: assert property (digit_strobe != 8'h00 |->
    digit_strobe == 8'h01 << {scan_select_bit2, scan_select_bit1, scan_select_bit0})
    else $error("strobe differs from select code");
  a_scan_rotate: assert property ($changed(digit_strobe) && prev_reg != 8'h00 |->
    digit_strobe == {prev_reg[6:0], prev_reg[7]}) else $error("scan skipped a position");
  a_strobe_dwell: assert property ($changed(digit_strobe) |=> $stable(digit_strobe)[*8])
    else $error("strobe dwell too short");
  a_activity_pair: assert property (key_activity_n == !key_activity)
    else $error("activity outputs not complementary");
  a_test_segments: assert property (display_test && $past(display_test) |-> segment_drive == 7'h7f)
    else $error("segments not all lit in test");
  a_mode_exclusive: assert property (!(display_test && normal_operation))
    else $error("test and normal at once");
  a_activity_normal: assert property ($rose(key_activity) |-> normal_operation)
    else $error("key pulse outside normal mode");
  a_fast_idle: assert property ((!fast_rate) [*3] |-> fast_select_n)
    else $error("fast select active while off");
  a_fast_width: assert property ($fell(fast_select_n) |-> ##49 !fast_select_n ##1 fast_select_n)
    else $error("fast select pulse width");
  a_slow_width: assert property ($fell(slow_select_n) |-> ##99 !slow_select_n ##1 slow_select_n)
    else $error("slow select pulse width");
endmodule
bind display_keyboard_scanner scanner_checker checker_inst (.mclk, .rst_n, .fast_rate, .scan_select_bit0,
  .scan_select_bit1, .scan_select_bit2, .digit_strobe, .segment_drive, .key_activity, .key_activity_n,
  .display_test, .normal_operation, .fast_select_n, .slow_select_n);
`default_nettype wire

// ===== dv/keypad_matrix.sv
// keypad matrix model: at most one held key, return lines pulled up
// assumes active-high one-hot strobes from the scanner
`timescale 1ns/1ns
`default_nettype none
module keypad_matrix (
  input wire logic [7:0] digit_strobe,
  input wire logic held,
  input wire logic [1:0] col,
  input wire logic [2:0] row,
  output logic [6:0] ret_n
);
  // released lines go up through the pull-ups, never keep old data
  always_comb begin
    ret_n = 7'h7f;
    if (held) ret_n[row] = ~digit_strobe[col];
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the display and keyboard scanner
// assumes the keypad model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk = 0, rst_n = 0, ref_clk_1mhz = 0, fast_rate = 0, held = 0;
  logic [1:0] col = 0;
  logic [2:0] row = 0;
  logic [31:0] digit_codes = 0;
  logic [6:0] ret_n;
  wire scan_select_bit0, scan_select_bit1, scan_select_bit2, key_activity, key_activity_n;
  wire display_test, normal_operation, fast_select_n, slow_select_n;
  wire [7:0] digit_strobe;
  wire [6:0] segment_drive;
  wire [4:0] key_code;
  int fails = 0, n_checks = 0, i, n;
  logic [6:0] seg_tab [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

  display_keyboard_scanner #(.POWERUP_WINDOW_CYC(2000), .FAST_PERIOD_CYC(60000),
    .SLOW_PERIOD_CYC(1000000), .SCAN_DWELL_TICKS(2), .KEY_PULSE_CYC(25000)) dut (
    .mclk, .rst_n, .ref_clk_1mhz, .digit_codes, .fast_rate, .key_return_line0(ret_n[0]),
    .key_return_line1(ret_n[1]), .key_return_line2(ret_n[2]), .key_return_line3(ret_n[3]),
    .key_return_line4(ret_n[4]), .key_return_line5(ret_n[5]), .key_return_line6(ret_n[6]),
    .scan_select_bit0, .scan_select_bit1, .scan_select_bit2, .digit_strobe, .segment_drive,
    .key_activity, .key_activity_n, .key_code, .display_test, .normal_operation,
    .fast_select_n, .slow_select_n);
  keypad_matrix keypad (.digit_strobe, .held, .col, .row, .ret_n);

  always #2 mclk = ~mclk;
  // reference edges always fall 2 ns after an mclk rising edge; one period is 250 mclk cycles
  always #500 ref_clk_1mhz = ~ref_clk_1mhz;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bound(input bit ok);
    if (!ok) begin
      fails++;
      $display("unexpected wait bound: expected 1 seen 0");
      summarize();
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic press(input logic [1:0] c, input logic [2:0] r, input logic h);
    @(posedge mclk);
    col <= c;
    row <= r;
    held <= h;
  endtask
  task automatic wait_step(output int cyc);
    logic [7:0] s;
    s = digit_strobe;
    for (cyc = 1; cyc < 2000; cyc++) begin
      tick();
      if (digit_strobe !== s) break;
    end
    bound(cyc < 2000);
  endtask
  task automatic next_fall(output int cyc);
    for (cyc = 0; cyc < 8000 && fast_select_n === 1'b0; cyc++) tick();
    for (; cyc < 8000 && fast_select_n !== 1'b0; cyc++) tick();
    bound(cyc < 8000);
  endtask

  task automatic test_freeze();
    press(2'd0, 3'd0, 1'b1);
    for (i = 0; i < 3000 && display_test !== 1'b1; i++) tick();
    bound(i < 3000);
    tick();
    check("test segments", segment_drive, 7'h7f);
    press(2'd0, 3'd0, 1'b0);
    repeat (4500) tick();
    check("test holds", display_test, 1'b1);
    press(2'd2, 3'd6, 1'b1);
    for (i = 0; i < 10000 && normal_operation !== 1'b1; i++) tick();
    bound(i < 10000);
    check("test released", display_test, 1'b0);
    check("release pulse", key_activity, 1'b0);
    press(2'd2, 3'd6, 1'b0);
    $display("freeze test done");
  endtask

  task automatic test_scan();
    logic [31:0] word;
    for (int w = 0; w < 2; w++) begin
      word = w ? 32'hfedcba98 : 32'h76543210;
      wait_step(n);
      for (i = 0; i < 9000 && digit_strobe !== 8'h80; i++) tick();
      bound(i < 9000);
      @(posedge mclk);
      digit_codes <= word;
      #1;
      for (int p = 0; p < 8; p++) begin
        wait_step(n);
        if (p > 0) check("dwell cycles", n, 500);
        check("strobe", digit_strobe, 8'h01 << p);
        check("select", {scan_select_bit2, scan_select_bit1, scan_select_bit0}, p);
        check("segments", segment_drive, seg_tab[word[4*p +: 4]]);
      end
    end
    $display("scan test done");
  endtask

  task automatic test_keys();
    logic [2:0] rows [3] = '{3'd6, 3'd2, 3'd0};
    logic [4:0] codes [3] = '{5'd6, 5'd9, 5'd14};
    for (int k = 0; k < 3; k++) begin
      press(k[1:0], rows[k], 1'b1);
      for (i = 0; i < 9000 && key_code !== codes[k]; i++) tick();
      bound(i < 9000);
      check("key pulse", key_activity, 1'b1);
      check("key pulse inverse", key_activity_n, 1'b0);
    end
    for (n = 0; n < 30000 && key_activity === 1'b1; n++) tick();
    check("pulse cycles", n, 25000);
    press(2'd1, 3'd6, 1'b1);
    repeat (4500) tick();
    check("unused key code", key_code, 5'd14);
    check("unused key pulse", key_activity, 1'b0);
    press(2'd1, 3'd6, 1'b0);
    $display("key test done");
  endtask

  task automatic test_selects();
    for (i = 0; i < 3000 && slow_select_n !== 1'b0; i++) tick();
    check("slow burst", slow_select_n, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      fast_rate <= 1'b1;
      next_fall(n);
      next_fall(n);
      check("fast spacing", n, 6250);
      // let the pulse end whole; the third pulse of the group must then never come
      repeat (60) tick();
      @(posedge mclk);
      fast_rate <= 1'b0;
      for (i = 0; i < 7000 && fast_select_n === 1'b1; i++) tick();
      check("fast idle", fast_select_n, 1'b1);
    end
    $display("select test done");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    test_freeze();
    test_scan();
    test_keys();
    test_selects();
    summarize();
  end
endmodule
`default_nettype wire
